// *** src/pmbus_vout_params.svh ***
// Overview of operation
// - fault-clear command wipes all fault bits; a same-cycle new event keeps its bits
// - default save copies live config to store
// - default reload replaces live config
// - user save writes only changed words
// - user reload on command and power-up
// - user values overwrite default values
// - user reload sets security level 1
// - format byte low five bits: exponent
// - format byte top bits select representation
// - nominal voltage word, unsigned
// - trim word signed, limited to 150 mV
// - calibration word offsets like trim
// - effective target clamped to ceiling word
// - host-written ceiling limited to 115% of strap
// - margin high and low target words
// - slew rate word for transitions
// - switching rate 1 kHz steps, 200-640
// - rails per group, zero means 16
// - rail position sets phase offset
// - margin field picks nominal, low, high
`ifndef PMBUS_VOUT_PARAMS_SVH
`define PMBUS_VOUT_PARAMS_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_CLEAR_FAULT 8'h03
`define CMD_STORE_DFLT 8'h11
`define CMD_RESTORE_DFLT 8'h12
`define CMD_STORE_USER 8'h15
`define CMD_RESTORE_USER 8'h16
`define CMD_FORMAT 8'h20
`define CMD_NOMINAL 8'h21
`define CMD_TRIM 8'h22
`define CMD_CAL 8'h23
`define CMD_CEILING 8'h24
`define CMD_MARGIN_UP 8'h25
`define CMD_MARGIN_DOWN 8'h26
`define CMD_SLEW 8'h27
`define CMD_LOAD_LINE 8'h28
`define CMD_SW_RATE 8'h33
`define CMD_PHASE 8'h37
// ----------------------------------------
// word slots, fields and values
// ----------------------------------------
`define IDX_NOMINAL 4'd0
`define IDX_TRIM 4'd1
`define IDX_CAL 4'd2
`define IDX_CEILING 4'd3
`define IDX_UP 4'd4
`define IDX_DOWN 4'd5
`define IDX_SLEW 4'd6
`define IDX_LOAD 4'd7
`define IDX_RATE 4'd8
`define IDX_PHASE 4'd9
`define FORMAT_VALUE 8'h13
`define FMT_LINEAR 3'h0
`define FMT_VID 3'h1
`define FMT_DIRECT 3'h2
`define MARGIN_LOW 2'h1
`define MARGIN_HIGH 2'h2
`define TRIM_LIMIT 16'h04CC
`define CEIL_PCT 24'd115
`define PCT_BASE 24'd100
`define RATE_MIN 11'h0C8
`define RATE_MAX 11'h280
`define RAILS_ZERO 5'h10
`define DEF_NOMINAL 16'h2000
`define DEF_TRIM 16'h0000
`define DEF_CAL 16'h0000
`define DEF_CEILING 16'h3999
`define DEF_UP 16'h2333
`define DEF_DOWN 16'h1CCC
`define DEF_SLEW 16'hBA00
`define DEF_LOAD 16'h0000
`define DEF_RATE 16'h0140
`define DEF_PHASE 16'h0010
`define STORE_WAIT_MS 20
`define MCLK_KHZ 125000
`define SECURITY_USER 2'h1
`endif

// *** src/pmbus_vout_pkg.sv ***
package pmbus_vout_pkg;
    // serial engine states
    typedef enum logic [6:0] {
        IDLE = 7'h01,
        ADDR = 7'h02,
        CMD = 7'h04,
        WDATA = 7'h08,
        ACKING = 7'h10,
        RDATA = 7'h20,
        RACK = 7'h40
    } busState_e;

    typedef logic [9:0][15:0] wordBank_t;

    // all state of the decoder
    typedef struct packed {
        logic [1:0] sclPipe;
        logic sclLast;
        logic [1:0] sdaPipe;
        logic sdaLast;
        logic [15:0] strapMeta;
        logic [15:0] strapSync;
        busState_e state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic isRead;
        logic cmdSeen;
        logic hostAck;
        logic sdaDrive;
        logic [1:0] byteCnt;
        logic [7:0] cmd;
        logic [7:0] dataLo;
        logic [15:0] txWord;
        wordBank_t live;
        wordBank_t dflt;
        wordBank_t user;
        logic [9:0] userValid;
        logic [9:0] changed;
        logic [7:0] fault;
        logic [1:0] security;
        logic [21:0] busyCnt;
        logic boot;
        logic [15:0] target;
    } cfgState_s;
endpackage

// *** src/pmbus_vout_config_commands.sv ***
`timescale 1ns/1ps
`include "pmbus_vout_params.svh"
module pmbus_vout_config_commands
    import pmbus_vout_pkg::*;
#(
    parameter logic [6:0] DEVICE_ADDR = 7'h20, // arbitrary
    parameter int STORE_WAIT_CYCLES = `STORE_WAIT_MS * `MCLK_KHZ
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [15:0] voltageStrapPin,
    input wire logic [1:0] marginSelect,
    input wire logic [7:0] faultEvent,
    output logic [7:0] faultStatus,
    output logic [7:0] voltageFormat,
    output logic [15:0] targetVoltage,
    output logic [15:0] trimWord,
    output logic [15:0] calWord,
    output logic [15:0] slewRate,
    output logic [15:0] loadLine,
    output logic [15:0] switchRate,
    output logic [4:0] railCount,
    output logic [3:0] railPosition,
    output logic [1:0] securityLevel,
    output logic storeBusy
);

    // ----------------------------------------
    // factory contents and helpers
    // ----------------------------------------
    localparam wordBank_t FACTORY = {
        `DEF_PHASE, `DEF_RATE, `DEF_LOAD, `DEF_SLEW, `DEF_DOWN,
        `DEF_UP, `DEF_CEILING, `DEF_CAL, `DEF_TRIM, `DEF_NOMINAL
    };

    cfgState_s st;
    cfgState_s nx;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sendExec;
    logic wordWrite;
    logic idxValid;
    logic [3:0] cmdIdx;
    logic [23:0] strapProd;
    logic [15:0] ceilLimit;
    logic [15:0] selWord;
    logic [15:0] capped;
    logic signed [17:0] sumTrim;
    logic [15:0] ceilingWord;

    // command code to word slot
    always_comb begin
        idxValid = 1'b1;
        cmdIdx = `IDX_NOMINAL;
        unique case (st.cmd)
            `CMD_NOMINAL: cmdIdx = `IDX_NOMINAL;
            `CMD_TRIM: cmdIdx = `IDX_TRIM;
            `CMD_CAL: cmdIdx = `IDX_CAL;
            `CMD_CEILING: cmdIdx = `IDX_CEILING;
            `CMD_MARGIN_UP: cmdIdx = `IDX_UP;
            `CMD_MARGIN_DOWN: cmdIdx = `IDX_DOWN;
            `CMD_SLEW: cmdIdx = `IDX_SLEW;
            `CMD_LOAD_LINE: cmdIdx = `IDX_LOAD;
            `CMD_SW_RATE: cmdIdx = `IDX_RATE;
            `CMD_PHASE: cmdIdx = `IDX_PHASE;
            default: idxValid = 1'b0; // format byte lands here
        endcase
    end

    // limit a written word to its legal range
    function automatic logic [15:0] clampWrite(
        input logic [3:0] idx,
        input logic [15:0] val,
        input logic [15:0] lim
    );
        logic [15:0] res;
        res = val;
        if (idx == `IDX_TRIM || idx == `IDX_CAL) begin
            if (signed'(val) > signed'(`TRIM_LIMIT)) begin
                res = `TRIM_LIMIT;
            end else if (signed'(val) < -signed'(`TRIM_LIMIT)) begin
                res = 16'(-signed'(`TRIM_LIMIT));
            end
        end else if (idx == `IDX_CEILING && val > lim) begin
            res = lim;
        end else if (idx == `IDX_RATE && val[15:11] == 5'h00) begin
            if (val[10:0] < `RATE_MIN) begin
                res = {5'h00, `RATE_MIN};
            end else if (val[10:0] > `RATE_MAX) begin
                res = {5'h00, `RATE_MAX};
            end
        end
        return res;
    endfunction

    // ----------------------------------------
    // bus events and strap limit
    // ----------------------------------------
    assign sclRise = st.sclPipe[1] & ~st.sclLast;
    assign sclFall = ~st.sclPipe[1] & st.sclLast;
    assign startSeen = st.sclPipe[1] & st.sclLast & st.sdaLast & ~st.sdaPipe[1];
    assign stopSeen = st.sclPipe[1] & st.sclLast & ~st.sdaLast & st.sdaPipe[1];
    assign sendExec = stopSeen && st.state != IDLE && !st.isRead && st.cmdSeen && st.byteCnt == 2'd0;
    assign wordWrite = sclFall && st.state == WDATA && st.bitCnt == 4'd8 && st.byteCnt == 2'd1;
    assign strapProd = 24'(st.strapSync) * `CEIL_PCT;
    assign ceilLimit = (strapProd / `PCT_BASE > 24'h00FFFF) ? 16'hFFFF : 16'(strapProd / `PCT_BASE);
    assign ceilingWord = st.live[`IDX_CEILING];

    // margin select, ceiling clamp and offsets
    always_comb begin
        unique case (marginSelect)
            `MARGIN_LOW: selWord = st.live[`IDX_DOWN];
            `MARGIN_HIGH: selWord = st.live[`IDX_UP];
            default: selWord = st.live[`IDX_NOMINAL];
        endcase
        capped = (selWord > ceilingWord) ? ceilingWord : selWord;
        sumTrim = signed'({2'b00, capped}) + 18'(signed'(st.live[`IDX_TRIM]))
            + 18'(signed'(st.live[`IDX_CAL]));
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nx = st;
        nx.sclPipe = {st.sclPipe[0], sclIn};
        nx.sclLast = st.sclPipe[1];
        nx.sdaPipe = {st.sdaPipe[0], sdaIn};
        nx.sdaLast = st.sdaPipe[1];
        nx.strapMeta = voltageStrapPin;
        nx.strapSync = st.strapMeta;
        // serial engine
        if (startSeen) begin
            nx.state = ADDR;
            nx.bitCnt = 4'd0;
            nx.byteCnt = 2'd0;
            nx.cmdSeen = 1'b0;
            nx.sdaDrive = 1'b0;
        end else if (stopSeen) begin
            nx.state = IDLE;
            nx.sdaDrive = 1'b0;
        end else begin
            unique case (st.state)
                IDLE: begin
                    nx.sdaDrive = 1'b0;
                end
                ADDR, CMD, WDATA: begin
                    if (sclRise && st.bitCnt != 4'd8) begin
                        nx.shift = {st.shift[6:0], st.sdaPipe[1]};
                        nx.bitCnt = st.bitCnt + 4'd1;
                    end else if (sclFall && st.bitCnt == 4'd8) begin
                        nx.bitCnt = 4'd0;
                        nx.sdaDrive = 1'b1;
                        nx.state = ACKING;
                        if (st.state == ADDR) begin
                            // busy or booting: address is not acknowledged
                            if (st.shift[7:1] != DEVICE_ADDR || st.busyCnt != 22'd0 || st.boot) begin
                                nx.sdaDrive = 1'b0;
                                nx.state = IDLE;
                            end
                            nx.isRead = st.shift[0];
                            if (st.cmd == `CMD_FORMAT) begin
                                nx.txWord = {8'h00, `FORMAT_VALUE};
                            end else if (idxValid) begin
                                nx.txWord = st.live[cmdIdx];
                            end else begin
                                nx.txWord = 16'hFFFF;
                            end
                        end else if (st.state == CMD) begin
                            nx.cmd = st.shift;
                            nx.cmdSeen = 1'b1;
                        end else begin
                            if (st.byteCnt == 2'd0) begin
                                nx.dataLo = st.shift;
                            end
                            if (st.byteCnt != 2'd2) begin
                                nx.byteCnt = st.byteCnt + 2'd1;
                            end
                        end
                    end
                end
                ACKING: begin
                    if (sclFall) begin
                        nx.sdaDrive = 1'b0;
                        if (st.isRead) begin
                            nx.state = RDATA;
                            nx.shift = st.txWord[7:0];
                            nx.sdaDrive = ~st.txWord[7];
                            nx.txWord = {8'hFF, st.txWord[15:8]};
                        end else begin
                            nx.state = st.cmdSeen ? WDATA : CMD;
                        end
                    end
                end
                RDATA: begin
                    if (sclRise) begin
                        nx.bitCnt = st.bitCnt + 4'd1;
                    end else if (sclFall) begin
                        if (st.bitCnt == 4'd8) begin
                            nx.sdaDrive = 1'b0;
                            nx.bitCnt = 4'd0;
                            nx.state = RACK;
                        end else begin
                            nx.sdaDrive = ~st.shift[3'd7 - st.bitCnt[2:0]];
                        end
                    end
                end
                RACK: begin
                    if (sclRise) begin
                        nx.hostAck = ~st.sdaPipe[1];
                    end else if (sclFall) begin
                        nx.state = IDLE;
                        if (st.hostAck) begin
                            nx.state = RDATA;
                            nx.shift = st.txWord[7:0];
                            nx.sdaDrive = ~st.txWord[7];
                            nx.txWord = {8'hFF, st.txWord[15:8]};
                        end
                    end
                end
                default: begin
                    nx.state = IDLE;
                    nx.sdaDrive = 1'b0;
                end
            endcase
        end
        // word writes; the format byte has no slot
        if (wordWrite && idxValid) begin
            nx.live[cmdIdx] = clampWrite(cmdIdx, {st.shift, st.dataLo}, ceilLimit);
            nx.changed[cmdIdx] = 1'b1;
        end
        // hold-off counter after user save, user reload and power-up
        if (st.busyCnt != 22'd0) begin
            nx.busyCnt = st.busyCnt - 22'd1;
        end
        // fault bits: a new event beats the clear
        nx.fault = ((sendExec && st.cmd == `CMD_CLEAR_FAULT) ? 8'h00 : st.fault) | faultEvent;
        if (sendExec && st.cmd == `CMD_STORE_DFLT) begin
            nx.dflt = st.live;
        end
        if (sendExec && st.cmd == `CMD_RESTORE_DFLT) begin
            nx.live = st.dflt;
            nx.changed = 10'h000;
        end
        if (sendExec && st.cmd == `CMD_STORE_USER) begin
            for (int i = 0; i < 10; i++) begin
                if (st.changed[i]) begin
                    nx.user[i] = st.live[i];
                end
            end
            nx.userValid = st.userValid | st.changed;
            nx.busyCnt = 22'(STORE_WAIT_CYCLES);
        end
        // user reload, also the first step after power-up
        if ((sendExec && st.cmd == `CMD_RESTORE_USER) || st.boot) begin
            for (int i = 0; i < 10; i++) begin
                if (st.userValid[i]) begin
                    nx.live[i] = st.user[i];
                end
            end
            nx.changed = 10'h000;
            nx.security = `SECURITY_USER;
            nx.busyCnt = 22'(STORE_WAIT_CYCLES);
            nx.boot = 1'b0;
        end
        // effective target kept within zero and ceiling
        if (sumTrim < 18'sd0) begin
            nx.target = 16'h0000;
        end else if (sumTrim > signed'({2'b00, ceilingWord})) begin
            nx.target = ceilingWord;
        end else begin
            nx.target = sumTrim[15:0];
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st <= '0;
            st.sclPipe <= 2'b11;
            st.sclLast <= 1'b1;
            st.sdaPipe <= 2'b11;
            st.sdaLast <= 1'b1;
            st.state <= IDLE;
            st.live <= FACTORY;
            st.dflt <= FACTORY;
            st.boot <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign sdaOut = 1'b0;
    assign sdaOe = st.sdaDrive;
    assign faultStatus = st.fault;
    assign voltageFormat = `FORMAT_VALUE;
    assign targetVoltage = st.target;
    assign trimWord = st.live[`IDX_TRIM];
    assign calWord = st.live[`IDX_CAL];
    assign slewRate = st.live[`IDX_SLEW];
    assign loadLine = st.live[`IDX_LOAD];
    assign switchRate = st.live[`IDX_RATE];
    assign railCount = (st.live[`IDX_PHASE][7:4] == 4'h0) ? `RAILS_ZERO
        : {1'b0, st.live[`IDX_PHASE][7:4]};
    assign railPosition = st.live[`IDX_PHASE][3:0];
    assign securityLevel = st.security;
    assign storeBusy = (st.busyCnt != 22'd0);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence clearSeq;
        sendExec && st.cmd == `CMD_CLEAR_FAULT && faultEvent == 8'h00;
    endsequence
    sequence userSaveSeq;
        sendExec && st.cmd == `CMD_STORE_USER;
    endsequence
    sequence userLoadSeq;
        sendExec && st.cmd == `CMD_RESTORE_USER;
    endsequence
    // a host word write landing in a slot
    sequence wordSeq;
        wordWrite && idxValid;
    endsequence

    fault_clear_a: assert property (clearSeq |=> faultStatus == 8'h00)
        else $error("fault bits survive clear");
    default_save_a: assert property (sendExec && st.cmd == `CMD_STORE_DFLT |=> st.dflt == $past(st.live))
        else $error("default store not copied");
    default_load_a: assert property (sendExec && st.cmd == `CMD_RESTORE_DFLT |=> st.live == $past(st.dflt))
        else $error("default reload not applied");
    user_keep_a: assert property (userSaveSeq and !st.changed[0] |=> $stable(st.user[0]))
        else $error("unchanged word stored");
    user_save_a: assert property (userSaveSeq and st.changed[0] |=> st.user[0] == $past(st.live[0]))
        else $error("changed word not stored");
    store_busy_a: assert property (userSaveSeq or userLoadSeq |=> storeBusy ##1 storeBusy)
        else $error("hold-off not started");
    security_set_a: assert property (userLoadSeq |=> securityLevel == `SECURITY_USER)
        else $error("security level not set");
    format_fixed_a: assert property (voltageFormat == `FORMAT_VALUE)
        else $error("format byte changed");
    target_cap_a: assert property (1'b1 |=> targetVoltage <= $past(ceilingWord))
        else $error("target above ceiling");
    trim_range_a: assert property (signed'(trimWord) <= signed'(`TRIM_LIMIT)
        && signed'(trimWord) >= -signed'(`TRIM_LIMIT))
        else $error("trim out of range");
    margin_low_a: assert property (marginSelect == `MARGIN_LOW && trimWord == 16'h0000 && calWord == 16'h0000
        && st.live[`IDX_DOWN] <= ceilingWord |=> targetVoltage == $past(st.live[`IDX_DOWN]))
        else $error("margin low target wrong");
    rail_count_a: assert property (railCount != 5'h00 && railCount <= `RAILS_ZERO)
        else $error("rail count out of range");
    // written ceiling never above the strap limit
    ceiling_write_a: assert property (wordSeq and cmdIdx == `IDX_CEILING |=> ceilingWord <= $past(ceilLimit))
        else $error("ceiling above strap limit");
    // integer rate writes land inside the supported span
    rate_write_a: assert property (wordSeq and cmdIdx == `IDX_RATE && st.shift[7:3] == 5'h00
        |=> switchRate >= {5'h00, `RATE_MIN} && switchRate <= {5'h00, `RATE_MAX})
        else $error("rate outside span");
    // a fault event always leaves its bits set
    fault_set_a: assert property (faultEvent != 8'h00 |=> (faultStatus & $past(faultEvent)) == $past(faultEvent))
        else $error("fault event lost");

endmodule

// *** tb/pmbus_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bus host: scl and sda pulled low only
// ----------------------------------------
module pmbus_host_model #(
    parameter logic [6:0] TARGET_ADDR = 7'h20 // arbitrary
) (
    input wire logic mclk,
    input wire logic sdaWire,
    output logic sclLow,
    output logic sdaLow
);
    int nacks;
    // both lines released, wire sits high
    initial begin
        sclLow = 1'b0;
        sdaLow = 1'b0;
        nacks = 0;
    end
    // wait n cycles, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one bit; data moves well after scl fell
    task automatic bitx(input logic low, output logic s);
        tick(3);
        sdaLow = low;
        tick(10);
        sclLow = 1'b0;
        tick(10);
        s = sdaWire;
        sclLow = 1'b1;
    endtask
    // start or repeated start, leaves scl low
    task automatic start();
        tick(3);
        sdaLow = 1'b0;
        tick(10);
        sclLow = 1'b0;
        tick(10);
        sdaLow = 1'b1;
        tick(10);
        sclLow = 1'b1;
    endtask
    task automatic stop();
        tick(3);
        sdaLow = 1'b1;
        tick(10);
        sclLow = 1'b0;
        tick(10);
        sdaLow = 1'b0;
        tick(10);
    endtask
    // byte msb first, then the acknowledge bit
    task automatic xbyte(input logic [7:0] tx, input logic rd, input logic last, output logic [7:0] rx);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(!tx[i], s);
            rx[i] = s;
        end
        bitx(rd && !last, s);
        if (!rd && s) nacks++;
    endtask
    task automatic sendByte(input logic [7:0] code);
        logic [7:0] rx;
        start();
        xbyte({TARGET_ADDR, 1'b0}, 1'b0, 1'b0, rx);
        xbyte(code, 1'b0, 1'b0, rx);
        stop();
    endtask
    // low byte first, then high byte
    task automatic writeWord(input logic [7:0] code, input logic [15:0] w);
        logic [7:0] rx;
        start();
        xbyte({TARGET_ADDR, 1'b0}, 1'b0, 1'b0, rx);
        xbyte(code, 1'b0, 1'b0, rx);
        xbyte(w[7:0], 1'b0, 1'b0, rx);
        xbyte(w[15:8], 1'b0, 1'b0, rx);
        stop();
    endtask
    task automatic readWord(input logic [7:0] code, output logic [15:0] w);
        logic [7:0] rx;
        start();
        xbyte({TARGET_ADDR, 1'b0}, 1'b0, 1'b0, rx);
        xbyte(code, 1'b0, 1'b0, rx);
        start();
        xbyte({TARGET_ADDR, 1'b1}, 1'b0, 1'b0, rx);
        xbyte(8'hFF, 1'b1, 1'b0, rx);
        w[7:0] = rx;
        xbyte(8'hFF, 1'b1, 1'b1, rx);
        w[15:8] = rx;
        stop();
    endtask
endmodule

// *** tb/pmbus_vout_config_commands_tb_top.sv ***
`timescale 1ns/1ps
`include "pmbus_vout_params.svh"
// ----------------------------------------
// bench top: host, design, reference model
// ----------------------------------------
module pmbus_vout_config_commands_tb_top;
    localparam int STRAP = 16'h2000;
    localparam int CEIL = STRAP * 115 / 100;
    localparam int TL = `TRIM_LIMIT;
    logic mclk, reset_n, sdaOut, sdaOe, sclLow, sdaLow, sdaWire, storeBusy;
    logic [1:0] marginSelect, securityLevel;
    logic [7:0] faultEvent, faultStatus, voltageFormat, fe;
    logic [15:0] targetVoltage, trimWord, calWord, slewRate, loadLine, switchRate, rdw;
    logic [4:0] railCount;
    logic [3:0] railPosition;
    logic [7:0] cmdOf[10] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h33, 8'h37};
    int idxT[8] = '{8, 8, 1, 2, 9, 3, 0, 7};
    int valT[8] = '{100, 700, 16'h1000, 16'hF000, 16'h0A05, 16'hFFFF, 16'h3000, 16'h0012};
    int numErrors, checksDone, cycles;
    int live[10], dflt[10], usr[10];
    bit valid[10], chg[10];
    assign sdaWire = (sdaOe ? sdaOut : 1'b1) & !sdaLow;
    pmbus_host_model #(.TARGET_ADDR(7'h20)) pmbus_host_model_i (
        .mclk(mclk), .sdaWire(sdaWire), .sclLow(sclLow), .sdaLow(sdaLow));
    pmbus_vout_config_commands #(.DEVICE_ADDR(7'h20), .STORE_WAIT_CYCLES(50)) pmbus_vout_config_commands_i (
        .mclk(mclk), .reset_n(reset_n), .sclIn(!sclLow), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .voltageStrapPin(16'(STRAP)), .marginSelect(marginSelect), .faultEvent(faultEvent),
        .faultStatus(faultStatus), .voltageFormat(voltageFormat), .targetVoltage(targetVoltage),
        .trimWord(trimWord), .calWord(calWord), .slewRate(slewRate), .loadLine(loadLine),
        .switchRate(switchRate), .railCount(railCount), .railPosition(railPosition),
        .securityLevel(securityLevel), .storeBusy(storeBusy));
    // clock and hang guard
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            numErrors++;
            reportAndStop();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input int exp);
        checksDone++;
        if (seen !== 16'(exp)) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, 16'(exp), seen);
        end
    endtask
    // reference clamping of written words
    function automatic int lim(input int idx, input int v);
        int c;
        c = v;
        if (idx == 1 || idx == 2) c = v > 32767 ? v - 65536 : v;
        if (idx == 1 || idx == 2) c = (c > TL ? TL : (c < -TL ? -TL : c)) & 16'hFFFF;
        if (idx == 3 && v > CEIL) c = CEIL;
        if (idx == 8 && v < 2048) c = v < 200 ? 200 : (v > 640 ? 640 : v);
        return c;
    endfunction
    function automatic int tgt(input int m);
        int s;
        s = m == 1 ? live[5] : (m == 2 ? live[4] : live[0]);
        s = s > live[3] ? live[3] : s;
        s = s + (live[1] > 32767 ? live[1] - 65536 : live[1]) + (live[2] > 32767 ? live[2] - 65536 : live[2]);
        return s < 0 ? 0 : (s > live[3] ? live[3] : s);
    endfunction
    task automatic compareAll();
        for (int m = 0; m < 4; m++) begin
            marginSelect = 2'(m);
            tick(6);
            check("target", targetVoltage, tgt(m));
        end
        check("trim", trimWord, live[1]);
        check("cal", calWord, live[2]);
        check("slew", slewRate, live[6]);
        check("loadline", loadLine, live[7]);
        check("rate", switchRate, live[8]);
        check("rails", railCount, live[9][7:4] == 0 ? 16 : live[9][7:4]);
        check("position", railPosition, live[9][3:0]);
    endtask
    task automatic writeCfg(input int idx, input int v);
        pmbus_host_model_i.writeWord(cmdOf[idx], 16'(v));
        live[idx] = lim(idx, v);
        chg[idx] = 1'b1;
        compareAll();
    endtask
    task automatic waitIdle();
        for (int n = 0; n < 1000 && storeBusy !== 1'b0; n++) tick(1);
        check("idle", storeBusy, 0);
    endtask
    // store and restore commands applied to the model
    task automatic sendCmd(input logic [7:0] code);
        pmbus_host_model_i.sendByte(code);
        for (int i = 0; i < 10; i++) begin
            if (code == 8'h11) dflt[i] = live[i];
            if (code == 8'h15 && chg[i]) usr[i] = live[i];
            if (code == 8'h15 && chg[i]) valid[i] = 1'b1;
            if (code == 8'h12 || (code == 8'h16 && valid[i])) live[i] = code == 8'h12 ? dflt[i] : usr[i];
            if (code == 8'h12 || code == 8'h16) chg[i] = 1'b0;
        end
        if (code == 8'h15 || code == 8'h16) begin
            tick(2);
            check("busy", storeBusy, 1);
            waitIdle();
        end
        compareAll();
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        mclk = 1'b0;
        reset_n = 1'b0;
        marginSelect = 2'h0;
        faultEvent = 8'h00;
        dflt = '{`DEF_NOMINAL, `DEF_TRIM, `DEF_CAL, `DEF_CEILING, `DEF_UP, `DEF_DOWN, `DEF_SLEW, `DEF_LOAD,
            `DEF_RATE, `DEF_PHASE};
        live = dflt;
        void'($urandom(96));
        tick(5);
        reset_n = 1'b1;
        tick(3);
        check("boot busy", storeBusy, 1);
        waitIdle();
        check("level", securityLevel, 1);
        check("exponent", voltageFormat[4:0], `FORMAT_VALUE & 8'h1F);
        check("mode", voltageFormat[7:5], `FMT_LINEAR);
        compareAll();
        $display("test boot done");
        for (int i = 0; i < 10; i++) writeCfg(i, $urandom_range(0, 16'hFFFF));
        for (int i = 0; i < 8; i++) writeCfg(idxT[i], valT[i]);
        for (int i = 0; i < 10; i++) begin
            pmbus_host_model_i.readWord(cmdOf[i], rdw);
            check("readback", rdw, live[i]);
        end
        pmbus_host_model_i.writeWord(8'h20, 16'h00FF);
        pmbus_host_model_i.readWord(8'h20, rdw);
        check("format read", rdw[7:0], `FORMAT_VALUE);
        check("format pin", voltageFormat, `FORMAT_VALUE);
        $display("test words done");
        fe = 8'($urandom_range(1, 255));
        faultEvent = fe;
        tick(1);
        faultEvent = 8'h00;
        tick(3);
        check("faults set", faultStatus, fe);
        sendCmd(8'h03);
        check("faults clear", faultStatus, 0);
        $display("test faults done");
        writeCfg(0, 16'h1800);
        sendCmd(8'h11);
        writeCfg(0, 16'h1000);
        sendCmd(8'h12);
        writeCfg(1, 16'h0100);
        sendCmd(8'h15);
        writeCfg(0, 16'h1900);
        writeCfg(1, 16'h0200);
        sendCmd(8'h16);
        sendCmd(8'h12);
        sendCmd(8'h16);
        check("level", securityLevel, 1);
        check("nacks", 16'(pmbus_host_model_i.nacks), 0);
        $display("test stores done");
        reportAndStop();
    end
endmodule
